// ==== src/orrm_pkg.sv ====
package orrm_pkg;

   localparam int DATA_W = 8;
   localparam int ADDR_W = 16;
   localparam int LOW_REGS = 32;
   localparam int IDX_W = 5;
   localparam int DELAY_W = 12;

   // byte addresses of the decoded areas
   localparam logic [ADDR_W-1:0] LOW_PAGE_FIRST = 16'h0000;
   localparam logic [ADDR_W-1:0] LOW_PAGE_LAST = 16'h001f;
   localparam logic [ADDR_W-1:0] CAN_FIRST = 16'h0020;
   localparam logic [ADDR_W-1:0] CAN_LAST = 16'h003d;
   localparam logic [ADDR_W-1:0] EEPROM_OPTIONS_ADDR = 16'h0100;
   localparam logic [ADDR_W-1:0] MASK_OPTION_ADDR = 16'h7fde;

   // low page register offsets
   localparam logic [IDX_W-1:0] PORT_A_DATA = 5'h00;
   localparam logic [IDX_W-1:0] PORT_B_DATA = 5'h01;
   localparam logic [IDX_W-1:0] PORT_C_DATA = 5'h02;
   localparam logic [IDX_W-1:0] PORT_D_INPUT = 5'h03;
   localparam logic [IDX_W-1:0] PORT_A_DIRECTION = 5'h04;
   localparam logic [IDX_W-1:0] PORT_B_DIRECTION = 5'h05;
   localparam logic [IDX_W-1:0] PORT_C_DIRECTION = 5'h06;
   localparam logic [IDX_W-1:0] NVM_AND_CLOCK_OUT_CONTROL = 5'h07;
   localparam logic [IDX_W-1:0] ADC_RESULT = 5'h08;
   localparam logic [IDX_W-1:0] ADC_STATUS_CONTROL = 5'h09;
   localparam logic [IDX_W-1:0] PULSE_LENGTH_A = 5'h0a;
   localparam logic [IDX_W-1:0] PULSE_LENGTH_B = 5'h0b;
   localparam logic [IDX_W-1:0] MISCELLANEOUS_CONTROL = 5'h0c;
   localparam logic [IDX_W-1:0] SERIAL_RATE_SELECT = 5'h0d;
   localparam logic [IDX_W-1:0] SERIAL_CONTROL_1 = 5'h0e;
   localparam logic [IDX_W-1:0] SERIAL_CONTROL_2 = 5'h0f;
   localparam logic [IDX_W-1:0] SERIAL_STATUS = 5'h10;
   localparam logic [IDX_W-1:0] SERIAL_DATA = 5'h11;
   localparam logic [IDX_W-1:0] TIMER_CONTROL = 5'h12;
   localparam logic [IDX_W-1:0] TIMER_STATUS = 5'h13;
   localparam logic [IDX_W-1:0] CAPTURE_1_HIGH = 5'h14;
   localparam logic [IDX_W-1:0] CAPTURE_1_LOW = 5'h15;
   localparam logic [IDX_W-1:0] COMPARE_1_HIGH = 5'h16;
   localparam logic [IDX_W-1:0] COMPARE_1_LOW = 5'h17;
   localparam logic [IDX_W-1:0] FREE_COUNTER_HIGH = 5'h18;
   localparam logic [IDX_W-1:0] FREE_COUNTER_LOW = 5'h19;
   localparam logic [IDX_W-1:0] ALT_COUNTER_HIGH = 5'h1a;
   localparam logic [IDX_W-1:0] ALT_COUNTER_LOW = 5'h1b;
   localparam logic [IDX_W-1:0] CAPTURE_2_HIGH = 5'h1c;
   localparam logic [IDX_W-1:0] CAPTURE_2_LOW = 5'h1d;
   localparam logic [IDX_W-1:0] COMPARE_2_HIGH = 5'h1e;
   localparam logic [IDX_W-1:0] COMPARE_2_LOW = 5'h1f;

   // reset values, the zero one and those that are not zero
   localparam logic [DATA_W-1:0] RESET_ZERO = 8'h00;
   localparam logic [DATA_W-1:0] RESET_MISC_BASE = 8'h10;
   localparam logic [DATA_W-1:0] RESET_SERIAL_STATUS = 8'hc0;
   localparam logic [DATA_W-1:0] RESET_COUNTER_HIGH = 8'hff;
   localparam logic [DATA_W-1:0] RESET_COUNTER_LOW = 8'hfc;

   // software writable bits per register
   localparam logic [DATA_W-1:0] WMASK_ALL = 8'hff;
   localparam logic [DATA_W-1:0] WMASK_NONE = 8'h00;
   localparam logic [DATA_W-1:0] WMASK_ADC_STATUS = 8'h6f;
   localparam logic [DATA_W-1:0] WMASK_MISC = 8'h7e;

   // field positions
   localparam int MISC_POWER_ON_BIT = 7;
   localparam int MISC_WATCHDOG_ENABLE_BIT = 0;
   localparam int MASK_WATCHDOG_BIT = 7;
   localparam int MASK_OSC_DIVIDE_BY_TWO_BIT = 6;
   localparam int MASK_SHORT_DELAY_BIT = 4;

   // delay lengths in bus cycles, divide ratios
   localparam logic [DELAY_W-1:0] POR_LONG_CYCLES = 12'd4064;
   localparam logic [DELAY_W-1:0] POR_SHORT_CYCLES = 12'd16;
   localparam logic [3:0] OSC_DIVIDE_BY_TEN = 4'ha;
   localparam logic [3:0] OSC_DIVIDE_BY_TWO = 4'h2;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } orrm_bus_req_type;

   typedef struct packed {
      logic select;
      logic wr;
      logic rd;
      logic [5:0] offset;
      logic [DATA_W-1:0] wdata;
   } orrm_can_req_type;

   typedef struct packed {
      logic [3:0] osc_divide_ratio;
      logic cpu_hold;
   } orrm_clock_cfg_type;

   typedef enum logic [2:0] {
      SRC_NONE,
      SRC_LOW,
      SRC_CAN,
      SRC_OPTIONS,
      SRC_MASK
   } orrm_read_src_type;

   function automatic logic [DATA_W-1:0] reset_value(input logic [IDX_W-1:0] idx);
      case (idx)
         SERIAL_STATUS: reset_value = RESET_SERIAL_STATUS;
         FREE_COUNTER_HIGH, ALT_COUNTER_HIGH: reset_value = RESET_COUNTER_HIGH;
         FREE_COUNTER_LOW, ALT_COUNTER_LOW: reset_value = RESET_COUNTER_LOW;
         MISCELLANEOUS_CONTROL: reset_value = RESET_MISC_BASE;
         default: reset_value = RESET_ZERO;
      endcase
   endfunction

   function automatic logic [DATA_W-1:0] write_mask(input logic [IDX_W-1:0] idx);
      case (idx)
         PORT_D_INPUT, ADC_RESULT, SERIAL_STATUS, TIMER_STATUS, CAPTURE_1_HIGH, CAPTURE_1_LOW,
         FREE_COUNTER_HIGH, FREE_COUNTER_LOW, ALT_COUNTER_HIGH, ALT_COUNTER_LOW,
         CAPTURE_2_HIGH, CAPTURE_2_LOW: write_mask = WMASK_NONE;
         ADC_STATUS_CONTROL: write_mask = WMASK_ADC_STATUS;
         MISCELLANEOUS_CONTROL: write_mask = WMASK_MISC;
         default: write_mask = WMASK_ALL;
      endcase
   endfunction

   function automatic logic in_range(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] lo,
                                     input logic [ADDR_W-1:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

endpackage

// ==== src/orrm_top.sv ====
// What this block does
// - affected revision forces 4064-cycle delay and, outside bootloader mode, divide-by-ten during every reset
// - mask option byte chooses delay length and divide ratio otherwise
// - earlier revision bootloader: ratio ten if CAN pin high, two if low
// - later revisions bootloader: ratio two regardless of CAN pin
// - CAN pin high maps CAN controller registers at 0x0020 to 0x003d
// - power-on reset sets bit 7 of miscellaneous register
// - watchdog enable bit loaded from mask option after reset
// - EEPROM options byte at 0x0100 untouched by reset
// - mask option byte at 0x7fde untouched by reset
`timescale 1ns/100ps
module orrm_top #(
   parameter bit EARLY_REVISION = 1'b1
) (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   input wire orrm_pkg::orrm_bus_req_type i_bus,
   output logic [orrm_pkg::DATA_W-1:0] o_rdata,
   input wire logic i_power_on,
   input wire logic i_can_enable_pin,
   input wire logic i_bootloader_mode,
   input wire logic [orrm_pkg::DATA_W-1:0] i_mask_option_cells,
   input wire logic [orrm_pkg::DATA_W-1:0] i_eeprom_cells,
   output logic o_eeprom_write,
   output logic [orrm_pkg::DATA_W-1:0] o_eeprom_wdata,
   input wire logic [orrm_pkg::LOW_REGS-1:0][orrm_pkg::DATA_W-1:0] i_periph_values,
   output logic [orrm_pkg::LOW_REGS-1:0][orrm_pkg::DATA_W-1:0] o_regs,
   output orrm_pkg::orrm_can_req_type o_can,
   input wire logic [orrm_pkg::DATA_W-1:0] i_can_rdata,
   output orrm_pkg::orrm_clock_cfg_type o_clock_cfg
);

   logic [orrm_pkg::LOW_REGS-1:0][orrm_pkg::DATA_W-1:0] regs_q;
   logic [orrm_pkg::LOW_REGS-1:0][orrm_pkg::DATA_W-1:0] regs_d;
   logic [orrm_pkg::LOW_REGS-1:0][orrm_pkg::DATA_W-1:0] regs_rst;
   orrm_pkg::orrm_read_src_type src_q;
   orrm_pkg::orrm_read_src_type src_d;
   logic [orrm_pkg::DATA_W-1:0] rdata_q;
   logic [orrm_pkg::DATA_W-1:0] rdata_d;
   logic [orrm_pkg::DELAY_W-1:0] delay_cnt_q;
   logic hold_q;
   orrm_pkg::orrm_clock_cfg_type cfg_q;
   orrm_pkg::orrm_clock_cfg_type cfg_d;
   logic eeprom_write_q;
   logic [orrm_pkg::DATA_W-1:0] eeprom_wdata_q;

   // address decode
   wire logic [orrm_pkg::IDX_W-1:0] bus_idx = i_bus.addr[orrm_pkg::IDX_W-1:0];
   wire logic hit_low = orrm_pkg::in_range(i_bus.addr, orrm_pkg::LOW_PAGE_FIRST, orrm_pkg::LOW_PAGE_LAST);
   wire logic hit_can = i_can_enable_pin &&
                        orrm_pkg::in_range(i_bus.addr, orrm_pkg::CAN_FIRST, orrm_pkg::CAN_LAST);
   wire logic hit_options = (i_bus.addr == orrm_pkg::EEPROM_OPTIONS_ADDR);
   wire logic hit_mask = (i_bus.addr == orrm_pkg::MASK_OPTION_ADDR);
   wire logic low_wr = i_bus.wr && hit_low;

   // mask option selections
   wire logic [orrm_pkg::DELAY_W-1:0] mask_delay = i_mask_option_cells[orrm_pkg::MASK_SHORT_DELAY_BIT] ?
                                                   orrm_pkg::POR_SHORT_CYCLES : orrm_pkg::POR_LONG_CYCLES;
   wire logic [3:0] mask_ratio = i_mask_option_cells[orrm_pkg::MASK_OSC_DIVIDE_BY_TWO_BIT] ?
                                 orrm_pkg::OSC_DIVIDE_BY_TWO : orrm_pkg::OSC_DIVIDE_BY_TEN;
   wire logic [orrm_pkg::DELAY_W-1:0] delay_len = EARLY_REVISION ? orrm_pkg::POR_LONG_CYCLES : mask_delay;
   wire logic [3:0] boot_ratio = (EARLY_REVISION && i_can_enable_pin) ?
                                 orrm_pkg::OSC_DIVIDE_BY_TEN : orrm_pkg::OSC_DIVIDE_BY_TWO;
   wire logic [3:0] reset_ratio = EARLY_REVISION ? orrm_pkg::OSC_DIVIDE_BY_TEN : mask_ratio;
   wire logic delay_done = (delay_cnt_q == delay_len - 12'd1);

   // reset image of the low page
   always_comb begin
      for (int i = 0; i < orrm_pkg::LOW_REGS; i++) begin
         regs_rst[i] = orrm_pkg::reset_value(orrm_pkg::IDX_W'(i));
      end
      regs_rst[orrm_pkg::MISCELLANEOUS_CONTROL][orrm_pkg::MISC_POWER_ON_BIT] =
         i_power_on || regs_q[orrm_pkg::MISCELLANEOUS_CONTROL][orrm_pkg::MISC_POWER_ON_BIT];
      regs_rst[orrm_pkg::MISCELLANEOUS_CONTROL][orrm_pkg::MISC_WATCHDOG_ENABLE_BIT] =
         i_mask_option_cells[orrm_pkg::MASK_WATCHDOG_BIT];
   end

   // next value: writable bits from software, the rest mirrored from peripherals
   always_comb begin
      logic [orrm_pkg::DATA_W-1:0] m;
      m = '0;
      for (int i = 0; i < orrm_pkg::LOW_REGS; i++) begin
         m = orrm_pkg::write_mask(orrm_pkg::IDX_W'(i));
         regs_d[i] = (regs_q[i] & m) | (i_periph_values[i] & ~m);
         if (low_wr && bus_idx == orrm_pkg::IDX_W'(i)) begin
            regs_d[i] = (i_bus.wdata & m) | (i_periph_values[i] & ~m);
         end
      end
      // power-on flag only cleared by writing zero, watchdog bit held
      regs_d[orrm_pkg::MISCELLANEOUS_CONTROL][orrm_pkg::MISC_POWER_ON_BIT] =
         regs_q[orrm_pkg::MISCELLANEOUS_CONTROL][orrm_pkg::MISC_POWER_ON_BIT] &&
         !(low_wr && bus_idx == orrm_pkg::MISCELLANEOUS_CONTROL &&
           !i_bus.wdata[orrm_pkg::MISC_POWER_ON_BIT]);
      regs_d[orrm_pkg::MISCELLANEOUS_CONTROL][orrm_pkg::MISC_WATCHDOG_ENABLE_BIT] =
         regs_q[orrm_pkg::MISCELLANEOUS_CONTROL][orrm_pkg::MISC_WATCHDOG_ENABLE_BIT];
   end

   // read source and local read data
   always_comb begin
      src_d = orrm_pkg::SRC_NONE;
      rdata_d = '0;
      if (i_bus.rd) begin
         if (hit_low) begin
            src_d = orrm_pkg::SRC_LOW;
            rdata_d = regs_q[bus_idx];
         end else if (hit_can) begin
            src_d = orrm_pkg::SRC_CAN;
         end else if (hit_options) begin
            src_d = orrm_pkg::SRC_OPTIONS;
            rdata_d = i_eeprom_cells;
         end else if (hit_mask) begin
            src_d = orrm_pkg::SRC_MASK;
            rdata_d = i_mask_option_cells;
         end
      end
   end

   // divide ratio and cpu hold
   always_comb begin
      cfg_d.cpu_hold = hold_q && !delay_done;
      if (i_bootloader_mode) begin
         cfg_d.osc_divide_ratio = boot_ratio;
      end else if (cfg_d.cpu_hold) begin
         cfg_d.osc_divide_ratio = reset_ratio;
      end else begin
         cfg_d.osc_divide_ratio = mask_ratio;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         regs_q <= regs_rst;
      end else if (i_clk_en) begin
         regs_q <= regs_d;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         src_q <= orrm_pkg::SRC_NONE;
         rdata_q <= '0;
         eeprom_write_q <= 1'b0;
         eeprom_wdata_q <= '0;
      end else if (i_clk_en) begin
         src_q <= src_d;
         rdata_q <= rdata_d;
         eeprom_write_q <= i_bus.wr && hit_options;
         eeprom_wdata_q <= (i_bus.wr && hit_options) ? i_bus.wdata : eeprom_wdata_q;
      end
   end

   // power-on delay after every reset
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         delay_cnt_q <= '0;
         hold_q <= 1'b1;
         cfg_q.cpu_hold <= 1'b1;
         cfg_q.osc_divide_ratio <= i_bootloader_mode ? boot_ratio : reset_ratio;
      end else if (i_clk_en) begin
         hold_q <= cfg_d.cpu_hold;
         delay_cnt_q <= hold_q ? delay_cnt_q + 12'd1 : delay_cnt_q;
         cfg_q <= cfg_d;
      end
   end

   // CAN controller strobes pass straight through, its data answers next cycle
   assign o_can.select = hit_can;
   assign o_can.wr = i_bus.wr && hit_can;
   assign o_can.rd = i_bus.rd && hit_can;
   assign o_can.offset = i_bus.addr[5:0];
   assign o_can.wdata = i_bus.wdata;

   assign o_rdata = (src_q == orrm_pkg::SRC_CAN) ? i_can_rdata : rdata_q;
   assign o_regs = regs_q;
   assign o_eeprom_write = eeprom_write_q;
   assign o_eeprom_wdata = eeprom_wdata_q;
   assign o_clock_cfg = cfg_q;

endmodule

// ==== testbench/orrm_chk.sv ====
`timescale 1ns/100ps
module orrm_chk #(
   parameter bit EARLY_REVISION = 1'b1
) (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   input wire orrm_pkg::orrm_bus_req_type i_bus,
   input wire logic [orrm_pkg::DATA_W-1:0] o_rdata,
   input wire logic i_power_on,
   input wire logic i_can_enable_pin,
   input wire logic i_bootloader_mode,
   input wire logic [orrm_pkg::DATA_W-1:0] i_mask_option_cells,
   input wire logic [orrm_pkg::DATA_W-1:0] i_eeprom_cells,
   input wire logic o_eeprom_write,
   input wire logic [orrm_pkg::DATA_W-1:0] o_eeprom_wdata,
   input wire logic [orrm_pkg::LOW_REGS-1:0][orrm_pkg::DATA_W-1:0] o_regs,
   input wire orrm_pkg::orrm_can_req_type o_can,
   input wire logic [orrm_pkg::DATA_W-1:0] i_can_rdata,
   input wire orrm_pkg::orrm_clock_cfg_type o_clock_cfg
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   wire can_hit = i_can_enable_pin && i_bus.addr >= 16'h0020 && i_bus.addr <= 16'h003d;
   wire rd_go = i_clk_en && i_bus.rd;
   wire wr_go = i_clk_en && i_bus.wr;
   sequence s_held;
      (i_clk_en && o_clock_cfg.cpu_hold && !i_bootloader_mode) [*2];
   endsequence
   sequence s_run;
      (i_clk_en && !o_clock_cfg.cpu_hold && !i_bootloader_mode) [*2];
   endsequence
   sequence s_boot;
      i_clk_en && i_bootloader_mode ##1 1'b1;
   endsequence
   a_can_map: assert property (can_hit && i_bus.rd |-> o_can.select && o_can.rd)
      else $error("can read not decoded");
   a_can_write: assert property (can_hit && i_bus.wr |-> o_can.select && o_can.wr &&
      o_can.offset == i_bus.addr[5:0] && o_can.wdata == i_bus.wdata)
      else $error("can write not decoded");
   a_can_off: assert property (!i_can_enable_pin |-> !o_can.select && !o_can.rd && !o_can.wr)
      else $error("can decoded with pin low");
   a_can_data: assert property (o_can.rd && i_clk_en |=> o_rdata == i_can_rdata)
      else $error("can read data not passed");
   a_opt_write: assert property (wr_go && i_bus.addr == 16'h0100 |=>
      o_eeprom_write && o_eeprom_wdata == $past(i_bus.wdata))
      else $error("options write not forwarded");
   a_opt_read: assert property (rd_go && i_bus.addr == 16'h0100 |=> o_rdata == $past(i_eeprom_cells))
      else $error("options read wrong");
   a_mask_read: assert property (rd_go && i_bus.addr == 16'h7fde |=> o_rdata == $past(i_mask_option_cells))
      else $error("mask byte read wrong");
   a_hold_ratio: assert property (s_held |-> !EARLY_REVISION || o_clock_cfg.osc_divide_ratio == 4'ha)
      else $error("ratio not forced during hold");
   a_run_ratio: assert property (s_run |->
      o_clock_cfg.osc_divide_ratio == ($past(i_mask_option_cells[6]) ? 4'h2 : 4'ha))
      else $error("ratio not from mask byte");
   a_boot_ratio: assert property (s_boot |->
      o_clock_cfg.osc_divide_ratio == ((EARLY_REVISION && $past(i_can_enable_pin)) ? 4'ha : 4'h2))
      else $error("bootloader ratio wrong");
   a_por_flag: assert property ($rose(i_rst_n) && $past(i_power_on) |-> o_regs[12][7])
      else $error("power-on flag not set");
   a_watchdog_enable_bit_load: assert property ($rose(i_rst_n) |-> o_regs[12][0] == $past(i_mask_option_cells[7]))
      else $error("watchdog bit not loaded");
   a_pla_write: assert property (wr_go && i_bus.addr == 16'h000a |=> o_regs[10] == $past(i_bus.wdata))
      else $error("register write lost");
endmodule
bind orrm_top orrm_chk #(.EARLY_REVISION(EARLY_REVISION)) u_chk (.i_clock(i_clock), .i_rst_n(i_rst_n),
   .i_clk_en(i_clk_en), .i_bus(i_bus), .o_rdata(o_rdata), .i_power_on(i_power_on),
   .i_can_enable_pin(i_can_enable_pin), .i_bootloader_mode(i_bootloader_mode),
   .i_mask_option_cells(i_mask_option_cells), .i_eeprom_cells(i_eeprom_cells), .o_eeprom_write(o_eeprom_write),
   .o_eeprom_wdata(o_eeprom_wdata), .o_regs(o_regs), .o_can(o_can), .i_can_rdata(i_can_rdata),
   .o_clock_cfg(o_clock_cfg));

// ==== testbench/tb_top.sv ====
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin miscompares++; \
   $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module tb_top;
   logic i_clock = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_clk_en = 1'b1;
   orrm_pkg::orrm_bus_req_type i_bus = '0;
   logic [7:0] o_rdata, o_eeprom_wdata, d, e;
   logic [7:0] can_rd = 8'h00, mask = 8'hd0, eep = 8'h00;
   logic i_power_on = 1'b1, pin = 1'b0, boot = 1'b0, o_eeprom_write, rd_seen = 1'b0;
   logic [31:0][7:0] periph = '0, o_regs, sh;
   orrm_pkg::orrm_can_req_type o_can;
   orrm_pkg::orrm_clock_cfg_type o_clock_cfg;
   orrm_pkg::orrm_clock_cfg_type late_cfg;
   int miscompares = 0, checked = 0, n;
   int rl[] = '{4, 5, 6, 7, 8, 9, 10, 11, 15, 16, 17, 24, 25, 26, 27};
   int wl[] = '{0, 1, 2, 4, 5, 6, 7, 10, 11, 13, 14, 15, 17, 18, 22, 23, 30, 31};
   logic [7:0] exp_q[$], ew_q[$];
   logic [15:0] adr_q[$];
   orrm_top i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en), .i_bus(i_bus), .o_rdata(o_rdata),
      .i_power_on(i_power_on), .i_can_enable_pin(pin), .i_bootloader_mode(boot), .i_mask_option_cells(mask),
      .i_eeprom_cells(eep), .o_eeprom_write(o_eeprom_write), .o_eeprom_wdata(o_eeprom_wdata),
      .i_periph_values(periph), .o_regs(o_regs), .o_can(o_can), .i_can_rdata(can_rd), .o_clock_cfg(o_clock_cfg));
   // later revision: mask byte delay and ratio, fixed bootloader ratio
   orrm_top #(.EARLY_REVISION(1'b0)) i_dut_late (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en),
      .i_bus(i_bus), .o_rdata(), .i_power_on(i_power_on), .i_can_enable_pin(pin), .i_bootloader_mode(boot),
      .i_mask_option_cells(mask), .i_eeprom_cells(eep), .o_eeprom_write(), .o_eeprom_wdata(),
      .i_periph_values(periph), .o_regs(), .o_can(), .i_can_rdata(can_rd), .o_clock_cfg(late_cfg));
   initial begin
      forever #5 i_clock = ~i_clock;
   end
   function automatic logic [7:0] rst_val(input int i);
      case (i)
         24, 26: return 8'hff;
         25, 27: return 8'hfc;
         16: return 8'hc0;
         default: return 8'h00;
      endcase
   endfunction
   task automatic bus(input logic [15:0] a, input logic [7:0] v, input logic w, input logic [7:0] x);
      @(posedge i_clock);
      i_bus <= '{addr: a, wdata: v, wr: w, rd: !w};
      if (!w) begin
         exp_q.push_back(x);
         adr_q.push_back(a);
      end
      if (w && a == 16'h0100) ew_q.push_back(v);
   endtask
   task automatic idle(input int c);
      @(posedge i_clock);
      i_bus <= '0;
      repeat (c) @(posedge i_clock);
   endtask
   task automatic do_reset(input logic por);
      @(posedge i_clock);
      i_rst_n <= 1'b0;
      i_power_on <= por;
      i_bus <= '0;
      repeat (3) @(posedge i_clock);
      i_rst_n <= 1'b1;
      i_power_on <= 1'b0;
   endtask
   task automatic end_of_test;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // result side: one note taken off per read answer or options write
   always @(posedge i_clock) begin : mon
      rd_seen <= i_bus.rd && i_clk_en && i_rst_n;
      if (rd_seen) begin
         e = exp_q.pop_front();
         `CHK($sformatf("rdata %h", adr_q.pop_front()), e, o_rdata)
      end
      if (o_eeprom_write === 1'b1) begin
         e = ew_q.pop_front();
         `CHK("eeprom_wdata", e, o_eeprom_wdata)
      end
   end
   initial begin
      repeat (30000) @(posedge i_clock);
      miscompares++;
      end_of_test();
   end
   initial begin
      void'($urandom(97));
      for (int i = 0; i < 32; i++) periph[i] = rst_val(i);
      mask = 8'(($urandom() & 32'h2f) | 32'hd0);
      eep = 8'($urandom());
      periph[12] = 8'h01;
      do_reset(1'b1);
      repeat (3) @(posedge i_clock);
      #1;
      `CHK("ratio_in_hold", 4'ha, o_clock_cfg.osc_divide_ratio)
      `CHK("late_ratio_in_hold", 4'h2, late_cfg.osc_divide_ratio)
      repeat (12) @(posedge i_clock);
      #1;
      `CHK("late_hold_15", 1'b1, late_cfg.cpu_hold)
      @(posedge i_clock);
      #1;
      `CHK("late_hold_16", 1'b0, late_cfg.cpu_hold)
      n = 16;
      while (o_clock_cfg.cpu_hold !== 1'b0 && n < 5000) begin
         @(posedge i_clock);
         #1;
         n++;
      end
      `CHK("hold_length", 1'b1, n >= 4064 && n <= 4067)
      repeat (2) @(posedge i_clock);
      #1;
      `CHK("ratio_after_hold", 4'h2, o_clock_cfg.osc_divide_ratio)
      foreach (rl[k]) bus(16'(rl[k]), 8'h00, 1'b0, rst_val(rl[k]));
      bus(16'h000c, 8'h00, 1'b0, 8'h91);
      foreach (wl[k]) begin
         sh[wl[k]] = 8'($urandom());
         bus(16'(wl[k]), sh[wl[k]], 1'b1, 8'h00);
      end
      d = 8'($urandom());
      bus(16'h0018, d, 1'b1, 8'h00);
      bus(16'h0009, d, 1'b1, 8'h00);
      bus(16'h000c, 8'h00, 1'b1, 8'h00);
      foreach (wl[k]) bus(16'(wl[k]), 8'h00, 1'b0, sh[wl[k]]);
      bus(16'h0018, 8'h00, 1'b0, 8'hff);
      bus(16'h0009, 8'h00, 1'b0, d & 8'h6f);
      bus(16'h000c, 8'h00, 1'b0, 8'h01);
      bus(16'h0050, 8'h00, 1'b0, 8'h00);
      bus(16'h7fde, 8'h00, 1'b0, mask);
      bus(16'h0100, d, 1'b1, 8'h00);
      bus(16'h0100, 8'h00, 1'b0, eep);
      can_rd <= 8'($urandom());
      idle(0);
      pin <= 1'b1;
      bus(16'h0020, 8'h00, 1'b0, can_rd);
      bus(16'h003d, 8'h00, 1'b0, can_rd);
      bus(16'h0021, d, 1'b1, 8'h00);
      bus(16'h003e, 8'h00, 1'b0, 8'h00);
      idle(0);
      pin <= 1'b0;
      bus(16'h0020, 8'h00, 1'b0, 8'h00);
      idle(0);
      i_clk_en <= 1'b0;
      bus(16'h000a, ~sh[10], 1'b1, 8'h00);
      idle(0);
      i_clk_en <= 1'b1;
      bus(16'h000a, 8'h00, 1'b0, sh[10]);
      idle(0);
      boot <= 1'b1;
      pin <= 1'b1;
      repeat (2) @(posedge i_clock);
      #1;
      `CHK("boot_ratio_pin_high", 4'ha, o_clock_cfg.osc_divide_ratio)
      `CHK("late_boot_ratio", 4'h2, late_cfg.osc_divide_ratio)
      @(posedge i_clock);
      pin <= 1'b0;
      repeat (2) @(posedge i_clock);
      #1;
      `CHK("boot_ratio_pin_low", 4'h2, o_clock_cfg.osc_divide_ratio)
      @(posedge i_clock);
      boot <= 1'b0;
      mask <= mask & 8'h7f;
      periph[12] <= 8'h00;
      do_reset(1'b0);
      bus(16'h000c, 8'h00, 1'b0, 8'h10);
      bus(16'h000a, 8'h00, 1'b0, 8'h00);
      bus(16'h7fde, 8'h00, 1'b0, mask);
      bus(16'h0100, 8'h00, 1'b0, eep);
      do_reset(1'b1);
      bus(16'h000c, 8'h00, 1'b0, 8'h90);
      idle(3);
      end_of_test();
   end
endmodule
